// ### rtl/dbp_pkg.sv
// Purpose: shared constants and types of both debug link ends
// Assumes: one 50 MHz clock drives both ends
// Notes: link frames are 16 bits, msb first, 4-bit code then 12-bit arg
package dbp_pkg;
  localparam int BIT_DIV = 4;
  localparam logic [1:0] PH_LAST = 2'(BIT_DIV - 1);
  localparam logic [1:0] PH_SAMPLE = 2'h1;
  localparam logic [4:0] N_BITS = 5'h10;

  localparam logic [3:0] OP_SEL = 4'h1;
  localparam logic [3:0] OP_BRK_ADDR = 4'h2;
  localparam logic [3:0] OP_BRK_CFG = 4'h3;
  localparam logic [3:0] OP_TRC_ADDR = 4'h4;
  localparam logic [3:0] OP_TRC_CFG = 4'h5;
  localparam logic [3:0] OP_DELAY = 4'h6;
  localparam logic [3:0] OP_RAM_INIT = 4'h7;

  localparam logic [3:0] MT_PC = 4'h1;
  localparam logic [3:0] MT_RD = 4'h2;
  localparam logic [3:0] MT_WR = 4'h3;
  localparam logic [3:0] MT_LOSS = 4'hf;

  localparam logic [1:0] SEL_JTAG = 2'h3;
  localparam logic [1:0] SEL_LPD = 2'h1;
  localparam logic CORE_MAIN = 1'b0;
  localparam logic CORE_PERI = 1'b1;

  typedef enum logic [2:0] {
    CLS_PLAIN = 3'h0,
    CLS_SYSTEM_CALL_INSTR = 3'h1,
    CLS_BITOP = 3'h2,
    CLS_FRAME = 3'h3,
    CLS_PUSH = 3'h4
  } dbp_cls_t;

  localparam int BC_EN = 11;
  localparam int BC_DQ = 10;
  localparam int BC_RD = 9;
  localparam int BC_WR = 8;
  localparam int TC_RT = 2;
  localparam int TC_FULL = 3;
  localparam int TC_DLY = 4;
  localparam int TC_RD = 5;
  localparam int TC_WR = 6;
  localparam logic [1:0] MODE_SEC = 2'h1;
  localparam logic [1:0] MODE_PT = 2'h2;

  typedef enum logic [3:0] {
    TS_OFF = 4'h1,
    TS_ARM = 4'h2,
    TS_RUN = 4'h4,
    TS_HALT = 4'h8
  } dbp_trc_t;

  typedef enum logic [2:0] {
    PS_IDLE = 3'h1,
    PS_SEL = 3'h2,
    PS_RAM = 3'h4
  } dbp_pseq_t;

  localparam logic [11:0] CFG_RST = 12'h000;
  localparam logic [11:0] TRC_DEPTH = 12'h400;
  localparam logic [11:0] RAM_LAST = 12'h0ff;
  localparam logic [11:0] EI_TABLE_ADDR = 12'h040;

  localparam logic [3:0] REG_STAT = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_INFO = 4'h8;
  localparam logic [3:0] PR_CMD = 4'h0;
  localparam logic [3:0] PR_CTRL = 4'h4;
  localparam logic [3:0] PR_STAT = 4'h8;
  localparam logic [3:0] PR_RX = 4'hc;

  localparam int NUM_EV = 4;
  localparam int EV_BRK = 0;
  localparam int EV_LOSS = 1;
  localparam int EV_STOP = 2;
  localparam int EV_RAM = 3;
endpackage

// ### rtl/dbp_link_if.sv
// Purpose: four one-way pins of the low pin count debug link
// Assumes: both ends on the same clock, pins resynchronised at receivers
// Notes: cmd pins go probe to device, trc pins device to probe
`timescale 1ns/1ps
interface dbp_link_if;
  logic cmd_frm;
  logic cmd_dat;
  logic trc_frm;
  logic trc_dat;
  modport dev (
    input cmd_frm,
    input cmd_dat,
    output trc_frm,
    output trc_dat
  );
  modport probe (
    output cmd_frm,
    output cmd_dat,
    input trc_frm,
    input trc_dat
  );
endinterface

// ### rtl/dbp_ser_tx.sv
// Purpose: frame serialiser, one bit per BIT_DIV cycles
// Assumes: load is only honoured while busy is low
// Notes: one gap bit with frame low follows every word
`timescale 1ns/1ps
module dbp_ser_tx import dbp_pkg::*; (
  input logic clk,
  input logic reset,
  input logic load,
  input logic [15:0] word,
  output logic busy,
  output logic frm,
  output logic dat
);
  logic busy_r;
  logic frm_r;
  logic dat_r;
  logic [1:0] ph_r;
  logic [4:0] bit_r;
  logic [15:0] sh_r;
  wire bit_en = busy_r && ph_r == PH_LAST;

  assign busy = busy_r;
  assign frm = frm_r;
  assign dat = dat_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      frm_r <= 1'b0;
      dat_r <= 1'b0;
      ph_r <= 2'h0;
      bit_r <= 5'h00;
      sh_r <= 16'h0000;
    end else if (load && !busy_r) begin
      busy_r <= 1'b1;
      frm_r <= 1'b1;
      dat_r <= word[15];
      sh_r <= word;
      ph_r <= 2'h0;
      bit_r <= 5'h00;
    end else if (busy_r) begin
      ph_r <= bit_en ? 2'h0 : ph_r + 2'h1;
      if (bit_en) begin
        bit_r <= bit_r + 5'h01;
        sh_r <= {sh_r[14:0], 1'b0};
        dat_r <= sh_r[14];
        if (bit_r == N_BITS - 5'h01) begin
          frm_r <= 1'b0;
        end
        if (bit_r == N_BITS) begin
          busy_r <= 1'b0;
        end
      end
    end
  end
endmodule

// ### rtl/dbp_device.sv
// Purpose: device end: access break, trace, interface select, ram init
// Assumes: probe keeps its own duties; blank_init pulsed once at first power
// Notes on behaviour
// - peripheral core: no break on system_call_instr reads
// - main core: no break on bit-op writes or frame/table ops
// - main-core bit-op reads break only without data qualifier
// - probe never breaks on interrupt table address
// - probe talks over low pin link only
// - select 11 means jtag, 01 low pin link
// - probe sets select to 01 on connect
// - probe may restore 11 at disconnect
// - power loss keeps select at 01
// - probe may zero all ram at start
// - section trace includes instruction before start
// - dropped trace messages raise a loss flag; one dropped in the cycle the loss marker loads raises none
// - full and delay stop need realtime priority
// - point trace ignores data value conditions
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dbp_device import dbp_pkg::*; (
  input logic clk,
  input logic reset,
  input logic blank_init,
  input logic acc_valid,
  input logic acc_core,
  input logic acc_write,
  input dbp_cls_t acc_cls,
  input logic [11:0] acc_addr,
  input logic [7:0] acc_data,
  input logic fetch_valid,
  input logic [11:0] fetch_pc,
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic brk_req,
  output logic [1:0] if_sel,
  output logic ram_we,
  output logic [11:0] ram_addr,
  dbp_link_if.dev link
);
  logic [1:0] pin_a;
  logic [1:0] pin_b;
  logic [1:0] pin_c;
  logic [1:0] pin_s;
  logic [1:0] rx_ph_r;
  logic [4:0] rx_bit_r;
  logic [15:0] rx_sh_r;
  logic rx_done_r;
  logic [1:0] if_sel_r;
  logic [11:0] brk_addr_r;
  logic [11:0] brk_cfg_r;
  logic [11:0] trc_addr_r;
  logic [6:0] trc_cfg_r;
  logic [11:0] delay_r;
  dbp_trc_t trc_r;
  dbp_trc_t trc_nxt;
  logic [11:0] prev_pc_r;
  logic lost_r;
  logic [11:0] sent_r;
  logic dly_on_r;
  logic [11:0] dly_cnt_r;
  logic ram_we_r;
  logic [11:0] ram_addr_r;
  logic ram_done_r;
  logic [NUM_EV-1:0] stat_r;
  logic [NUM_EV-1:0] mask_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic brk_req_r;
  logic tx_busy;

  // pins: three flops, a level change counts once flops two and three agree
  wire [1:0] pin_in = {link.cmd_frm, link.cmd_dat};
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_a <= 2'h0;
      pin_b <= 2'h0;
      pin_c <= 2'h0;
    end else begin
      pin_a <= pin_in;
      pin_b <= pin_a;
      pin_c <= pin_b;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_ff @(posedge clk) begin
        if (reset) begin
          pin_s[gi] <= 1'b0;
        end else if (pin_b[gi] == pin_c[gi]) begin
          pin_s[gi] <= pin_c[gi];
        end
      end
    end
  endgenerate

  wire frm_s = pin_s[1];
  wire dat_s = pin_s[0];
  wire rx_take = frm_s && rx_bit_r != N_BITS && rx_ph_r == PH_SAMPLE;
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_ph_r <= 2'h0;
      rx_bit_r <= 5'h00;
      rx_sh_r <= 16'h0000;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= rx_take && rx_bit_r == N_BITS - 5'h01;
      if (!frm_s) begin
        rx_ph_r <= 2'h0;
        rx_bit_r <= 5'h00;
      end else if (rx_bit_r != N_BITS) begin
        rx_ph_r <= (rx_ph_r == PH_LAST) ? 2'h0 : rx_ph_r + 2'h1;
        if (rx_take) begin
          rx_sh_r <= {rx_sh_r[14:0], dat_s};
          rx_bit_r <= rx_bit_r + 5'h01;
        end
      end
    end
  end

  wire [3:0] cmd_op = rx_sh_r[15:12];
  wire [11:0] cmd_arg = rx_sh_r[11:0];
  wire lpd_on = if_sel_r == SEL_LPD;
  // with jtag selected only the select write is heard on this link
  wire cmd_ok = rx_done_r && (lpd_on || cmd_op == OP_SEL);
  wire cmd_sel = cmd_ok && cmd_op == OP_SEL;
  wire cmd_tcfg = cmd_ok && cmd_op == OP_TRC_CFG;
  wire cmd_ram = cmd_ok && cmd_op == OP_RAM_INIT;

  // option field is nonvolatile: reset and power loss leave it alone
  always_ff @(posedge clk) begin
    if (blank_init) begin
      if_sel_r <= SEL_JTAG;
    end else if (cmd_sel) begin
      if_sel_r <= cmd_arg[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      brk_addr_r <= CFG_RST;
      brk_cfg_r <= CFG_RST;
      trc_addr_r <= CFG_RST;
      trc_cfg_r <= CFG_RST[6:0];
      delay_r <= CFG_RST;
    end else if (cmd_ok) begin
      if (cmd_op == OP_BRK_ADDR) begin
        brk_addr_r <= cmd_arg;
      end
      if (cmd_op == OP_BRK_CFG) begin
        brk_cfg_r <= cmd_arg;
      end
      if (cmd_op == OP_TRC_ADDR) begin
        trc_addr_r <= cmd_arg;
      end
      if (cmd_op == OP_TRC_CFG) begin
        trc_cfg_r <= cmd_arg[6:0];
      end
      if (cmd_op == OP_DELAY) begin
        delay_r <= cmd_arg;
      end
    end
  end

  // access break
  wire bc_dq = brk_cfg_r[BC_DQ];
  wire dir_brk = acc_write ? brk_cfg_r[BC_WR] : brk_cfg_r[BC_RD];
  wire addr_hit = acc_valid && brk_cfg_r[BC_EN] && dir_brk &&
                  acc_addr == brk_addr_r;
  wire data_ok = !bc_dq || acc_data == brk_cfg_r[7:0];
  wire peri_blk = acc_core == CORE_PERI && acc_cls == CLS_SYSTEM_CALL_INSTR &&
                  !acc_write;
  wire main_frm = acc_cls == CLS_FRAME || acc_cls == CLS_PUSH ||
                  acc_cls == CLS_SYSTEM_CALL_INSTR;
  wire main_bit = acc_cls == CLS_BITOP && (acc_write || bc_dq);
  wire main_blk = acc_core == CORE_MAIN && (main_frm || main_bit);
  wire brk_hit = lpd_on && addr_hit && data_ok && !peri_blk && !main_blk;

  // trace
  wire [1:0] t_mode = trc_cfg_r[1:0];
  wire rt_prio = trc_cfg_r[TC_RT];
  wire dir_trc = acc_write ? trc_cfg_r[TC_WR] : trc_cfg_r[TC_RD];
  wire push_wr = acc_write && acc_cls == CLS_PUSH;
  // point mode matches address and direction only, never the value
  wire pt_ok = t_mode != MODE_PT || acc_addr == trc_addr_r;
  wire sec_start = trc_r == TS_ARM && fetch_valid &&
                   fetch_pc == trc_addr_r;
  wire acc_msg = trc_r == TS_RUN && acc_valid && dir_trc && !push_wr &&
                 pt_ok;
  wire msg_v = sec_start || acc_msg;
  // start message carries the fetch before the triggering one
  wire [15:0] msg_w = sec_start ? {MT_PC, prev_pc_r} :
                      {acc_write ? MT_WR : MT_RD, acc_addr};
  // no buffer: a message that meets a busy link is dropped
  wire send_loss = !tx_busy && lost_r;
  wire send_msg = !tx_busy && !lost_r && msg_v;
  wire lost_nxt = tx_busy && (msg_v || lost_r);
  wire ev_loss = tx_busy && msg_v;
  wire tx_load = send_loss || send_msg;
  wire [15:0] tx_word = send_loss ? {MT_LOSS, CFG_RST} : msg_w;
  wire full_hit = rt_prio && trc_cfg_r[TC_FULL] && send_msg &&
                  sent_r == TRC_DEPTH - 12'h001;
  wire dly_hit = rt_prio && dly_on_r && dly_cnt_r == delay_r;
  wire stop_ev = trc_r == TS_RUN && trc_nxt == TS_HALT;

  always_comb begin
    trc_nxt = trc_r;
    unique case (trc_r)
      TS_OFF, TS_HALT: trc_nxt = trc_r;
      TS_ARM: if (sec_start) trc_nxt = TS_RUN;
      TS_RUN: if (full_hit || dly_hit) trc_nxt = TS_HALT;
    endcase
    if (cmd_tcfg) begin
      if (cmd_arg[1:0] == MODE_SEC) begin
        trc_nxt = TS_ARM;
      end else if (cmd_arg[1:0] == MODE_PT) begin
        trc_nxt = TS_RUN;
      end else begin
        trc_nxt = TS_OFF;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trc_r <= TS_OFF;
      prev_pc_r <= CFG_RST;
      lost_r <= 1'b0;
      sent_r <= CFG_RST;
      dly_on_r <= 1'b0;
      dly_cnt_r <= CFG_RST;
    end else begin
      trc_r <= trc_nxt;
      lost_r <= lost_nxt;
      if (fetch_valid) begin
        prev_pc_r <= fetch_pc;
      end
      if (cmd_tcfg) begin
        sent_r <= CFG_RST;
        dly_on_r <= 1'b0;
        dly_cnt_r <= CFG_RST;
      end else begin
        if (send_msg) begin
          sent_r <= sent_r + 12'h001;
        end
        if (brk_hit && trc_cfg_r[TC_DLY] && trc_r == TS_RUN && !dly_on_r) begin
          dly_on_r <= 1'b1;
        end else if (dly_on_r && send_msg) begin
          dly_cnt_r <= dly_cnt_r + 12'h001;
        end
      end
    end
  end

  dbp_ser_tx u_tx (
    .clk(clk),
    .reset(reset),
    .load(tx_load),
    .word(tx_word),
    .busy(tx_busy),
    .frm(link.trc_frm),
    .dat(link.trc_dat)
  );

  // ram clear sweep, writes zero to every word
  always_ff @(posedge clk) begin
    if (reset) begin
      ram_we_r <= 1'b0;
      ram_addr_r <= CFG_RST;
      ram_done_r <= 1'b0;
    end else begin
      ram_done_r <= ram_we_r && ram_addr_r == RAM_LAST;
      if (cmd_ram && !ram_we_r) begin
        ram_we_r <= 1'b1;
        ram_addr_r <= CFG_RST;
      end else if (ram_we_r) begin
        ram_we_r <= ram_addr_r != RAM_LAST;
        ram_addr_r <= ram_addr_r + 12'h001;
      end
    end
  end

  // registers
  wire sel_stat = reg_addr == REG_STAT;
  wire sel_mask = reg_addr == REG_MASK;
  wire sel_info = reg_addr == REG_INFO;
  wire [NUM_EV-1:0] ev = {ram_done_r, stop_ev, ev_loss, brk_hit};
  wire [NUM_EV-1:0] w1c = (reg_wr && sel_stat) ? reg_wdata[3:0] : 4'h0;
  // a new event in the clearing cycle stays set
  wire [NUM_EV-1:0] stat_nxt = (stat_r & ~w1c) | ev;
  wire [NUM_EV-1:0] mask_nxt = (reg_wr && sel_mask) ? reg_wdata[3:0] : mask_r;
  wire [7:0] info = {trc_r, ram_we_r, lost_r, if_sel_r};
  wire [7:0] rd_mux = sel_stat ? {4'h0, stat_r} :
                      sel_mask ? {4'h0, mask_r} :
                      sel_info ? info : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      brk_req_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= reg_rd ? rd_mux : 8'h00;
      irq_r <= |(stat_nxt & mask_nxt);
      brk_req_r <= brk_hit;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign brk_req = brk_req_r;
  assign if_sel = if_sel_r;
  assign ram_we = ram_we_r;
  assign ram_addr = ram_addr_r;
endmodule

// ### rtl/dbp_probe.sv
// Purpose: probe end: sends commands, collects trace messages
// Assumes: host software drives the plain register port
// Notes: one command word may wait while the link is busy
`timescale 1ns/1ps
module dbp_probe import dbp_pkg::*; (
  input logic clk,
  input logic reset,
  input logic [3:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [15:0] reg_rdata,
  dbp_link_if.probe link
);
  logic [1:0] pin_a;
  logic [1:0] pin_b;
  logic [1:0] pin_c;
  logic [1:0] pin_s;
  logic [1:0] rx_ph_r;
  logic [4:0] rx_bit_r;
  logic [15:0] rx_sh_r;
  logic rx_done_r;
  dbp_pseq_t ps_r;
  dbp_pseq_t ps_nxt;
  logic pend_v_r;
  logic [15:0] pend_w_r;
  logic ram_opt_r;
  logic rx_v_r;
  logic [15:0] rx_w_r;
  logic loss_r;
  logic err_r;
  logic [15:0] rdata_r;
  logic tx_busy;

  wire [1:0] pin_in = {link.trc_frm, link.trc_dat};
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_a <= 2'h0;
      pin_b <= 2'h0;
      pin_c <= 2'h0;
    end else begin
      pin_a <= pin_in;
      pin_b <= pin_a;
      pin_c <= pin_b;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_ff @(posedge clk) begin
        if (reset) begin
          pin_s[gi] <= 1'b0;
        end else if (pin_b[gi] == pin_c[gi]) begin
          pin_s[gi] <= pin_c[gi];
        end
      end
    end
  endgenerate

  wire frm_s = pin_s[1];
  wire rx_take = frm_s && rx_bit_r != N_BITS && rx_ph_r == PH_SAMPLE;
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_ph_r <= 2'h0;
      rx_bit_r <= 5'h00;
      rx_sh_r <= 16'h0000;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= rx_take && rx_bit_r == N_BITS - 5'h01;
      if (!frm_s) begin
        rx_ph_r <= 2'h0;
        rx_bit_r <= 5'h00;
      end else if (rx_bit_r != N_BITS) begin
        rx_ph_r <= (rx_ph_r == PH_LAST) ? 2'h0 : rx_ph_r + 2'h1;
        if (rx_take) begin
          rx_sh_r <= {rx_sh_r[14:0], pin_s[0]};
          rx_bit_r <= rx_bit_r + 5'h01;
        end
      end
    end
  end

  wire busy_any = pend_v_r || ps_r != PS_IDLE;
  // a break on the interrupt table could trap the return path
  wire vec_bad = reg_wdata[15:12] == OP_BRK_ADDR &&
                 reg_wdata[11:0] == EI_TABLE_ADDR;
  wire cmd_wr = reg_wr && reg_addr == PR_CMD;
  wire ctl_wr = reg_wr && reg_addr == PR_CTRL;
  wire cmd_take = cmd_wr && !busy_any && !vec_bad;
  wire conn = ctl_wr && reg_wdata[0] && !busy_any;
  wire rej = (cmd_wr && !cmd_take) || (ctl_wr && reg_wdata[0] && busy_any);
  wire ld_sel = ps_r == PS_SEL && !tx_busy;
  wire ld_ram = ps_r == PS_RAM && !tx_busy;
  wire ld_pend = ps_r == PS_IDLE && pend_v_r && !tx_busy;
  wire [15:0] tx_word = ld_sel ? {OP_SEL, 10'h000, SEL_LPD} :
                        ld_ram ? {OP_RAM_INIT, CFG_RST} : pend_w_r;

  always_comb begin
    ps_nxt = ps_r;
    unique case (ps_r)
      PS_IDLE: if (conn) ps_nxt = PS_SEL;
      PS_SEL: if (ld_sel) ps_nxt = ram_opt_r ? PS_RAM : PS_IDLE;
      PS_RAM: if (ld_ram) ps_nxt = PS_IDLE;
    endcase
  end

  dbp_ser_tx u_tx (
    .clk(clk),
    .reset(reset),
    .load(ld_sel || ld_ram || ld_pend),
    .word(tx_word),
    .busy(tx_busy),
    .frm(link.cmd_frm),
    .dat(link.cmd_dat)
  );

  wire rd_rx = reg_rd && reg_addr == PR_RX;
  wire [3:0] w1c = (reg_wr && reg_addr == PR_STAT) ? reg_wdata[3:0] : 4'h0;
  wire rx_loss = rx_done_r && rx_sh_r[15:12] == MT_LOSS;
  wire [15:0] stat = {12'h000, err_r, loss_r, rx_v_r, busy_any || tx_busy};
  wire [15:0] rd_mux = reg_addr == PR_STAT ? stat :
                       reg_addr == PR_RX ? rx_w_r :
                       reg_addr == PR_CTRL ? {14'h0000, ram_opt_r, 1'b0} :
                       16'h0000;

  always_ff @(posedge clk) begin
    if (reset) begin
      ps_r <= PS_IDLE;
      pend_v_r <= 1'b0;
      pend_w_r <= 16'h0000;
      ram_opt_r <= 1'b0;
      rx_v_r <= 1'b0;
      rx_w_r <= 16'h0000;
      loss_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ps_r <= ps_nxt;
      if (cmd_take) begin
        pend_v_r <= 1'b1;
        pend_w_r <= reg_wdata;
      end else if (ld_pend) begin
        pend_v_r <= 1'b0;
      end
      if (ctl_wr) begin
        ram_opt_r <= reg_wdata[1];
      end
      if (rx_done_r) begin
        rx_w_r <= rx_sh_r;
      end
      rx_v_r <= rx_done_r || (rx_v_r && !rd_rx);
      loss_r <= rx_loss || (loss_r && !w1c[2]);
      err_r <= rej || (err_r && !w1c[3]);
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;
endmodule

// ### testbench/dbp_link_props.sv
// Purpose: link pin checks between the probe end and the device end
// Assumes: one clock, reset synchronous and active high
// Notes: frame counters are helper logic only
`timescale 1ns/1ps
module dbp_link_props (
  input logic clk,
  input logic reset,
  input logic cmd_frm,
  input logic cmd_dat,
  input logic trc_frm,
  input logic trc_dat
);
  logic [6:0] cc_r;
  logic [6:0] tc_r;

  // counts high cycles of the current frame
  always_ff @(posedge clk) begin
    cc_r <= (reset || !cmd_frm) ? 7'h00 : cc_r + 7'h01;
    tc_r <= (reset || !trc_frm) ? 7'h00 : tc_r + 7'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_cmd_gap;
    !cmd_frm [*4];
  endsequence
  sequence s_trc_gap;
    !trc_frm [*4];
  endsequence

  property p_cmd_len;
    $fell(cmd_frm) |-> cc_r == 7'h40;
  endproperty
  property p_cmd_gap;
    $fell(cmd_frm) |-> s_cmd_gap;
  endproperty
  property p_cmd_max;
    cmd_frm |-> cc_r < 7'h40;
  endproperty
  property p_cmd_bit;
    (cmd_frm && cc_r[1:0] != 2'h0) |-> $stable(cmd_dat);
  endproperty
  property p_trc_len;
    $fell(trc_frm) |-> tc_r == 7'h40;
  endproperty
  property p_trc_gap;
    $fell(trc_frm) |-> s_trc_gap;
  endproperty
  property p_trc_max;
    trc_frm |-> tc_r < 7'h40;
  endproperty
  property p_trc_bit;
    (trc_frm && tc_r[1:0] != 2'h0) |-> $stable(trc_dat);
  endproperty

  a_cmd_len: assert property (p_cmd_len)
    else $error("command frame length wrong");
  a_cmd_gap: assert property (p_cmd_gap)
    else $error("command gap too short");
  a_cmd_max: assert property (p_cmd_max)
    else $error("command frame too long");
  a_cmd_bit: assert property (p_cmd_bit)
    else $error("command bit changed early");
  a_trc_len: assert property (p_trc_len)
    else $error("trace frame length wrong");
  a_trc_gap: assert property (p_trc_gap)
    else $error("trace gap too short");
  a_trc_max: assert property (p_trc_max)
    else $error("trace frame too long");
  a_trc_bit: assert property (p_trc_bit)
    else $error("trace bit changed early");
endmodule

// ### testbench/debug_break_trace_port_tb.sv
// Purpose: self-checking bench of both link ends
// Assumes: both ends on one 50 MHz clock
// Notes: commands spaced 90 cycles, above one frame plus gap
`timescale 1ns/1ps
module debug_break_trace_port_tb import dbp_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, blank_init = 1'b0;
  logic acc_valid = 1'b0, acc_core = 1'b0, acc_write = 1'b0;
  logic fetch_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic p_wr = 1'b0, p_rd = 1'b0, sel_ok = 1'b0, bq = 1'b0;
  dbp_cls_t acc_cls = CLS_PLAIN;
  logic [11:0] acc_addr = 12'h000, fetch_pc = 12'h000, ram_addr;
  logic [11:0] ba = 12'h123;
  logic [7:0] acc_data = 8'h00, reg_wdata = 8'h00, reg_rdata, bd = 8'h5a;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] p_wd = 16'h0000, p_rdata, v;
  logic irq, brk_req, ram_we;
  logic [1:0] if_sel;
  int error_cnt = 0, checks = 0, cyc = 0, n;

  always #10 clk = ~clk;

  dbp_link_if link ();
  dbp_device dbp_device_inst (.clk, .reset, .blank_init, .acc_valid,
    .acc_core, .acc_write, .acc_cls, .acc_addr, .acc_data, .fetch_valid,
    .fetch_pc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .brk_req, .if_sel, .ram_we, .ram_addr, .link(link.dev));
  dbp_probe dbp_probe_inst (.clk, .reset, .reg_addr, .reg_wdata(p_wd),
    .reg_wr(p_wr), .reg_rd(p_rd), .reg_rdata(p_rdata),
    .link(link.probe));
  dbp_link_props dbp_link_props_inst (.clk, .reset,
    .cmd_frm(link.cmd_frm), .cmd_dat(link.cmd_dat),
    .trc_frm(link.trc_frm), .trc_dat(link.trc_dat));

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // one register cycle on the device port (dev=1) or the probe port
  task automatic rq(input logic dev, input logic wr, input logic [3:0] a,
      input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d[7:0];
    p_wd <= d;
    {reg_wr, reg_rd, p_wr, p_rd} <= {dev & wr, dev & !wr, !dev & wr,
      !dev & !wr};
    @(posedge clk);
    {reg_wr, reg_rd, p_wr, p_rd} <= 4'h0;
    #1 v = dev ? {8'h00, reg_rdata} : p_rdata;
  endtask

  task automatic cmd(input logic [3:0] op, input logic [11:0] arg);
    rq(1'b0, 1'b1, PR_CMD, {op, arg});
    repeat (90) @(posedge clk);
  endtask

  function automatic logic eb(input logic c, input logic w,
      input dbp_cls_t k, input logic [11:0] a, input logic [7:0] d);
    if (a != ba || (bq && d != bd))
      return 1'b0;
    if (c && k == CLS_SYSTEM_CALL_INSTR && !w)
      return 1'b0;
    if (!c && (k == CLS_FRAME || k == CLS_PUSH || k == CLS_SYSTEM_CALL_INSTR))
      return 1'b0;
    if (!c && k == CLS_BITOP && (w || bq))
      return 1'b0;
    return sel_ok;
  endfunction

  task automatic acc(input logic c, input logic w, input dbp_cls_t k,
      input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_core <= c;
    acc_write <= w;
    acc_cls <= k;
    acc_addr <= a;
    acc_data <= d;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1 chk("brk", 16'(eb(c, w, k, a, d)), 16'(brk_req));
  endtask

  task automatic fetch(input logic [11:0] p);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_pc <= p;
    @(posedge clk);
    fetch_valid <= 1'b0;
  endtask

  // hang guard, far above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    n = $urandom(32'h85cd_535e);
    @(posedge clk);
    blank_init <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    blank_init <= 1'b0;
    rq(1'b1, 1'b0, REG_INFO, 16'h0000);
    chk("info", 16'(SEL_JTAG), v & 16'h0003);
    // commands before select must be ignored
    cmd(OP_BRK_ADDR, ba);
    cmd(OP_BRK_CFG, 12'hb00);
    acc(CORE_MAIN, 1'b0, CLS_PLAIN, ba, 8'h00);
    rq(1'b0, 1'b1, PR_CTRL, 16'h0003);
    repeat (170) @(posedge clk);
    #1 chk("sel", 16'(SEL_LPD), 16'(if_sel));
    chk("ropt", 16'h0001, 16'(ram_we));
    // configs sent before select were dropped, so no break yet
    acc(CORE_MAIN, 1'b0, CLS_PLAIN, ba, 8'h00);
    sel_ok = 1'b1;
    cmd(OP_BRK_ADDR, ba);
    cmd(OP_BRK_CFG, 12'hb00);
    acc(CORE_PERI, 1'b0, CLS_SYSTEM_CALL_INSTR, ba, 8'h00);
    acc(CORE_PERI, 1'b1, CLS_SYSTEM_CALL_INSTR, ba, 8'h00);
    acc(CORE_MAIN, 1'b0, CLS_FRAME, ba, 8'h00);
    acc(CORE_MAIN, 1'b1, CLS_PUSH, ba, 8'h00);
    acc(CORE_MAIN, 1'b1, CLS_BITOP, ba, 8'h00);
    acc(CORE_MAIN, 1'b0, CLS_BITOP, ba, 8'h00);
    repeat (24)
      acc(1'($urandom), 1'($urandom), dbp_cls_t'($urandom_range(4)),
        $urandom_range(1) ? ba : 12'($urandom), 8'($urandom));
    bq = 1'b1;
    cmd(OP_BRK_CFG, {4'hf, bd});
    acc(CORE_MAIN, 1'b0, CLS_BITOP, ba, bd);
    acc(CORE_MAIN, 1'b0, CLS_PLAIN, ba, bd);
    acc(CORE_MAIN, 1'b0, CLS_PLAIN, ba, ~bd);
    rq(1'b1, 1'b1, REG_MASK, 16'h0000);
    chk("irq", 16'h0000, 16'(irq));
    rq(1'b1, 1'b1, REG_MASK, 16'h000f);
    chk("irq", 16'h0001, 16'(irq));
    rq(1'b1, 1'b1, REG_STAT, 16'h000f);
    chk("irq", 16'h0000, 16'(irq));
    rq(1'b1, 1'b0, 4'h2, 16'h0000);
    chk("unmapped", 16'h0000, v);
    cmd(OP_BRK_ADDR, EI_TABLE_ADDR);
    rq(1'b0, 1'b0, PR_STAT, 16'h0000);
    chk("err", 16'h0008, v & 16'h0008);
    rq(1'b0, 1'b1, PR_CMD, {OP_RAM_INIT, 12'h000});
    n = 0;
    repeat (400) begin
      @(posedge clk);
      #1 if (ram_we === 1'b1) begin
        chk("raddr", 16'(n), 16'(ram_addr));
        n++;
      end
    end
    chk("rcnt", 16'h0100, 16'(n));
    rq(1'b1, 1'b0, REG_STAT, 16'h0000);
    chk("rdone", 16'h0008, v & 16'h0008);
    cmd(OP_TRC_ADDR, 12'h2c4);
    cmd(OP_TRC_CFG, 12'h062);
    acc(CORE_MAIN, 1'b1, CLS_PUSH, 12'h2c4, 8'h3c);
    acc(CORE_MAIN, 1'b0, CLS_PLAIN, 12'h2c4, 8'h3c);
    repeat (90) @(posedge clk);
    rq(1'b0, 1'b0, PR_RX, 16'h0000);
    chk("rx", {MT_RD, 12'h2c4}, v);
    repeat (3) acc(CORE_MAIN, 1'b0, CLS_PLAIN, 12'h2c4, 8'h00);
    rq(1'b1, 1'b0, REG_STAT, 16'h0000);
    chk("loss", 16'h0002, v & 16'h0002);
    repeat (250) @(posedge clk);
    rq(1'b0, 1'b0, PR_RX, 16'h0000);
    chk("marker", 16'(MT_LOSS), 16'(v[15:12]));
    cmd(OP_TRC_ADDR, 12'h480);
    cmd(OP_TRC_CFG, 12'h001);
    fetch(12'h47c);
    fetch(12'h480);
    repeat (90) @(posedge clk);
    rq(1'b0, 1'b0, PR_RX, 16'h0000);
    chk("pre", {MT_PC, 12'h47c}, v);
    cmd(OP_DELAY, 12'h000);
    cmd(OP_TRC_CFG, 12'h012);
    acc(CORE_MAIN, 1'b0, CLS_PLAIN, ba, bd);
    repeat (4) @(posedge clk);
    rq(1'b1, 1'b0, REG_INFO, 16'h0000);
    chk("trc", 16'(TS_RUN), 16'(v[7:4]));
    cmd(OP_TRC_CFG, 12'h016);
    acc(CORE_MAIN, 1'b0, CLS_PLAIN, ba, bd);
    repeat (4) @(posedge clk);
    rq(1'b1, 1'b0, REG_INFO, 16'h0000);
    chk("trc", 16'(TS_HALT), 16'(v[7:4]));
    rq(1'b1, 1'b0, REG_STAT, 16'h0000);
    chk("stop", 16'h0004, v & 16'h0004);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("sel", 16'(SEL_LPD), 16'(if_sel));
    close_out();
  end
endmodule
